// [include/tsw_pkg.sv]
// Constants, types and address helper for the timeslot switch core
package tsw_pkg;
   localparam int          NSTREAM       = 16;
   localparam int          CM_AW         = 10;
   localparam int          DM_AW         = 11;
   localparam int          CM_DW         = 16;
   localparam int          DM_DW         = 8;
   localparam int          FIFO_DEPTH    = 8;
   localparam int          FIFO_W        = DM_AW + DM_DW;
   localparam int          CH_BASE_BITS  = 5;
   localparam logic [15:0] ADDR_CTRL     = 16'h0000;
   localparam logic [15:0] ADDR_STATUS   = 16'h0004;
   localparam logic [15:0] ADDR_BLKVAL   = 16'h0008;
   localparam logic [15:0] ADDR_IN_BASE  = 16'h0040;
   localparam logic [15:0] ADDR_OUT_BASE = 16'h0080;
   localparam logic [15:0] ADDR_CM_BASE  = 16'h1000;
   localparam logic [15:0] ADDR_DM_BASE  = 16'h2000;
   localparam int          CTRL_RATE     = 0;
   localparam int          CTRL_CLK      = 2;
   localparam int          CTRL_BIDIR    = 4;
   localparam int          CTRL_CONV     = 5;
   localparam int          CTRL_FREEZE   = 6;
   localparam int          CTRL_BLK      = 7;
   localparam logic [6:0]  CTRL_RESET    = 7'h00;
   localparam logic [15:0] BLKVAL_RESET  = 16'h0800;
   localparam int          STAT_BUSY     = 0;
   localparam int          STAT_OVR      = 1;
   localparam int          CM_MODE       = 10;
   localparam int          CM_CONST      = 12;

   typedef enum logic [1:0] {TSW_MODE_CONN, TSW_MODE_MSG, TSW_MODE_HIZ, TSW_MODE_RSVD} tsw_mode_t;
   typedef enum logic {BLK_IDLE, BLK_RUN} tsw_blk_t;

   // Packs stream and channel into a switch address; top bit flags out of range
   function automatic logic [10:0] tsw_chan_addr(input logic [3:0] stream,
                                                 input logic [7:0] ch,
                                                 input logic [1:0] rate);
      logic [12:0] a;
      a = (13'(stream) << (CH_BASE_BITS + int'(rate))) | 13'(ch);
      return {|a[12:10], a[9:0]};
   endfunction : tsw_chan_addr
endpackage : tsw_pkg

// [include/tsw_mem_if.sv]
// Memory port bundle between the switch core and its memories
interface tsw_mem_if #(parameter int AW = 10, parameter int DW = 16);
   logic          we;
   logic [AW-1:0] waddr;
   logic [DW-1:0] wdata;
   logic [AW-1:0] ra_addr;
   logic [DW-1:0] ra_data;
   logic [AW-1:0] rb_addr;
   logic [DW-1:0] rb_data;
   modport ctl (output we, waddr, wdata, ra_addr, rb_addr, input ra_data, rb_data);
   modport mem (input we, waddr, wdata, ra_addr, rb_addr, output ra_data, rb_data);
endinterface : tsw_mem_if

// [logic/tsw_mem.sv]
// One write port, two registered read ports memory
module tsw_mem #(
   parameter int AW = 10,
   parameter int DW = 16
) (
   input  wire logic pclk,
   tsw_mem_if.mem    m
);
   if ($bits(m.waddr) != AW || $bits(m.wdata) != DW) begin : g_chk
      $error("tsw_mem width mismatch");
   end
   logic [DW-1:0] store [2**AW];

   always_ff @(posedge pclk) begin
      if (m.we) begin
         store[m.waddr] <= m.wdata;
      end
      m.ra_data <= store[m.ra_addr];
      m.rb_data <= store[m.rb_addr];
   end
endmodule : tsw_mem

// [logic/tsw_fifo.sv]
// Valid and ready FIFO of parameter width and depth
module tsw_fifo #(
   parameter int W     = 19,
   parameter int DEPTH = 8
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int PW = $clog2(DEPTH);
   if (DEPTH < 2 || (2**PW) != DEPTH) begin : g_chk
      $error("tsw_fifo depth must be a power of two");
   end
   logic [W-1:0] slot [DEPTH];
   logic [PW-1:0] wp;
   logic [PW-1:0] rp;
   logic [PW:0]   count;
   wire push = in_valid & in_ready;
   wire pop  = out_valid & out_ready;

   assign in_ready  = (count != (PW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data  = slot[rp];

   always_ff @(posedge pclk) begin
      if (push) begin
         slot[wp] <= in_data;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wp    <= '0;
         rp    <= '0;
         count <= '0;
      end else begin
         wp    <= wp + PW'(push);
         rp    <= rp + PW'(pop);
         count <= count + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule : tsw_fifo

// [logic/tsw_core.sv]
// Timeslot switch core: TDM framing, data and connection memories, APB registers
// Overview of operation
// RULE1: Switch up to 1024 input to 1024 output channels over sixteen streams each.
// RULE2: Any input stream and channel may feed any output stream and channel.
// RULE3: One common stream rate, programmable 2.048, 4.096, 8.192 or 16.384 Mbps.
// RULE4: In bidirectional mode input comes from the output pins, inputs ignored.
// RULE5: Connection mode outputs the data memory byte named by the entry.
// RULE6: Message mode outputs the byte held in the entry itself, per channel.
// RULE7: High-impedance mode releases the pin for that one channel only.
// RULE8: Software reads and writes registers and connection memory, reads data memory only.
// RULE9: Processor port supports two bus styles; host drives its strobes.
// RULE10: Per channel choice of constant or minimum throughput delay.
// RULE11: Per input stream bit delay and sampling point before storing.
// RULE12: Per output stream whole bit and half bit advancement.
// RULE13: Timing source supplies 4.096, 8.192 or 16.384 MHz input clock.
// RULE14: Timing source supplies a frame pulse marking each frame boundary.
// RULE15: Block programming fills the whole connection memory with one value.
// RULE16: Two TDM timing conventions for frame pulse and launch edges; the code switches only the frame pulse polarity, launch edges stay the same.
// RULE17: Channels per stream are rate over 64 kbps, counted from frame pulse.
// RULE18: Every received channel is written to data memory by stream and channel; the code drops out of range channels and overrun bytes.
module tsw_core
   import tsw_pkg::*;
#(
   parameter int NSTR = NSTREAM
) (
   input  wire logic            pclk,
   input  wire logic            presetn,
   input  wire logic            psel,
   input  wire logic            penable,
   input  wire logic            pwrite,
   input  wire logic [15:0]     paddr,
   input  wire logic [31:0]     pwdata,
   output logic [31:0]          prdata,
   output logic                 pready,
   output logic                 pslverr,
   input  wire logic            bus_style_sel,
   input  wire logic            tdm_input_clock,
   input  wire logic            frame_pulse_input,
   input  wire logic [NSTR-1:0] serial_in_stream,
   input  wire logic [NSTR-1:0] serial_out_bidir_stream_i,
   output logic [NSTR-1:0]      serial_out_bidir_stream_o,
   output logic [NSTR-1:0]      serial_out_bidir_stream_oe
);
   if (NSTR < 1 || NSTR > NSTREAM) begin : g_chk
      $error("tsw_core stream count out of range");
   end

   logic [6:0]      ctrl;
   logic [15:0]     blk_val;
   logic            overrun;
   logic            ack;
   tsw_blk_t        blk_st;
   logic [9:0]      blk_addr;
   logic            tclk_q;
   logic            fp_prev;
   logic            fpar;
   logic [4:0]      ep;
   logic [10:0]     gbit;
   logic [3:0]      in_tim [NSTR];
   logic [2:0]      out_tim [NSTR];
   logic [7:0]      in_byte [NSTR];
   logic [7:0]      in_ch [NSTR];
   logic [NSTR-1:0] in_pend;
   logic [NSTR-1:0] in_bank;
   logic [NSTR-1:0] ovr_set;
   logic [NSTR-1:0] pend_clr;
   logic [NSTR-1:0] nhiz;
   logic [3:0]      scan;
   logic            pf_run;
   logic [3:0]      pf_s;
   logic [7:0]      nc;
   logic            s1_v;
   logic [3:0]      s1_s;
   logic            s1_over;
   logic            s2_v;
   logic [3:0]      s2_s;
   tsw_mode_t       s2_mode;
   logic [7:0]      s2_msg;
   logic            s2_hiz;
   logic [7:0]      nb [NSTR];

   tsw_mem_if #(.AW(CM_AW), .DW(CM_DW)) cm_bus ();
   tsw_mem_if #(.AW(DM_AW), .DW(DM_DW)) dm_bus ();

   // Control fields
   wire [1:0] rate   = ctrl[CTRL_RATE +: 2];
   wire [1:0] clksel = ctrl[CTRL_CLK +: 2];
   wire       bidir  = ctrl[CTRL_BIDIR];
   wire       conv   = ctrl[CTRL_CONV];
   wire       freeze = ctrl[CTRL_FREEZE];
   wire       busy   = (blk_st == BLK_RUN);

   // Frame timing from the sampled TDM clock
   wire [2:0]  clk_sum    = {1'b0, clksel} + 3'd1;
   wire [2:0]  cpb_sh     = (clk_sum > {1'b0, rate}) ? clk_sum - {1'b0, rate} : 3'd0; // [RULE13]
   wire [5:0]  edges      = 6'd2 << cpb_sh;
   wire [4:0]  ep_last    = 5'(edges - 6'd1);
   wire [4:0]  ep_half    = 5'(edges >> 1);
   wire [11:0] fbits      = 12'd256 << rate; // [RULE3] [RULE17]
   wire [10:0] fb_mask    = 11'(fbits - 12'd1);
   wire [7:0]  ch_mask    = 8'hff >> (2'd3 - rate); // [RULE17]
   wire        tedge      = tdm_input_clock ^ tclk_q;
   wire        fp_act     = conv ? frame_pulse_input : !frame_pulse_input; // [RULE16]
   wire        frame_start = tedge & fp_act & !fp_prev; // [RULE14] [RULE17]
   wire        ep_wrap    = (ep == ep_last);
   wire [4:0]  next_ep    = (frame_start | ep_wrap) ? 5'd0 : ep + 5'd1;
   wire [10:0] gb_inc     = (gbit == fb_mask) ? 11'd0 : gbit + 11'd1;
   wire [10:0] next_gbit  = frame_start ? 11'd0 : (ep_wrap ? gb_inc : gbit);
   wire        next_fpar  = frame_start ? !fpar : fpar;
   wire        chan_tick  = tedge & (next_ep == 5'd0) & (next_gbit[2:0] == 3'd0);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tclk_q  <= 1'b0;
         fp_prev <= 1'b0;
         fpar    <= 1'b0;
         ep      <= '0;
         gbit    <= '0;
      end else begin
         tclk_q <= tdm_input_clock;
         if (tedge) begin
            fp_prev <= fp_act;
            fpar    <= next_fpar;
            ep      <= next_ep;
            gbit    <= next_gbit;
         end
      end
   end

   // APB decode
   wire acc      = psel & penable;
   wire al       = (paddr[1:0] == 2'b00);
   wire hit_ctrl = al & (paddr == ADDR_CTRL);
   wire hit_stat = al & (paddr == ADDR_STATUS);
   wire hit_bval = al & (paddr == ADDR_BLKVAL);
   wire hit_in   = al & (paddr[15:6] == ADDR_IN_BASE[15:6]) & ({1'b0, paddr[5:2]} < 5'(NSTR));
   wire hit_out  = al & (paddr[15:6] == ADDR_OUT_BASE[15:6]) & ({1'b0, paddr[5:2]} < 5'(NSTR));
   wire hit_cm   = al & (paddr[15:12] == ADDR_CM_BASE[15:12]);
   wire hit_dm   = al & (paddr[15:13] == ADDR_DM_BASE[15:13]);
   wire mapped   = hit_ctrl | hit_stat | hit_bval | hit_in | hit_out | hit_cm | hit_dm;
   wire bad      = !mapped | (pwrite & hit_dm) | (pwrite & hit_cm & busy); // [RULE8]
   wire fire     = acc & pready;
   wire wr       = fire & pwrite & !bad;
   wire blk_go   = wr & hit_ctrl & pwdata[CTRL_BLK];
   wire [31:0] rd_val = hit_ctrl ? {25'h0, ctrl} :
                        hit_stat ? {30'h0, overrun, busy} :
                        hit_bval ? {16'h0, blk_val} :
                        hit_in   ? {28'h0, in_tim[paddr[5:2]]} :
                        hit_out  ? {29'h0, out_tim[paddr[5:2]]} :
                        hit_cm   ? {16'h0, cm_bus.rb_data} :
                        hit_dm   ? {24'h0, dm_bus.rb_data} : 32'h0;

   assign pready  = !bus_style_sel | ack; // [RULE9]
   assign pslverr = fire & bad;
   assign prdata  = (psel & !pwrite & !bad) ? rd_val : 32'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack     <= 1'b0;
         ctrl    <= CTRL_RESET;
         blk_val <= BLKVAL_RESET;
         overrun <= 1'b0;
      end else begin
         ack <= acc & !ack; // [RULE9]
         if (wr & hit_ctrl) begin
            ctrl <= pwdata[6:0];
         end
         if (wr & hit_bval) begin
            blk_val <= pwdata[15:0];
         end
         overrun <= (|ovr_set) | (overrun & !(wr & hit_stat & pwdata[STAT_OVR]));
      end
   end

   // Block programming of the connection memory
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         blk_st   <= BLK_IDLE;
         blk_addr <= '0;
      end else begin
         case (blk_st)
            BLK_IDLE: begin
               blk_addr <= '0;
               if (blk_go) begin
                  blk_st <= BLK_RUN; // [RULE15]
               end
            end
            BLK_RUN: begin
               blk_addr <= blk_addr + 10'd1;
               if (blk_addr == 10'h3ff) begin
                  blk_st <= BLK_IDLE;
               end
            end
            default: blk_st <= BLK_IDLE;
         endcase
      end
   end

   assign cm_bus.we      = busy | (wr & hit_cm); // [RULE8] [RULE15]
   assign cm_bus.waddr   = busy ? blk_addr : paddr[11:2];
   assign cm_bus.wdata   = busy ? blk_val : pwdata[15:0];
   assign cm_bus.rb_addr = paddr[11:2];
   assign dm_bus.rb_addr = paddr[12:2]; // [RULE8]

   // Received bytes pass through the FIFO into the data memory
   logic              f_irdy;
   logic              f_ov;
   logic [FIFO_W-1:0] f_od;
   wire  [10:0]       in_ca = tsw_chan_addr(scan, in_ch[scan], rate); // [RULE1]
   wire               f_iv  = in_pend[scan] & !in_ca[10];
   wire               f_ordy = !freeze;

   assign pend_clr       = (in_pend[scan] & (in_ca[10] | f_irdy)) ? (NSTR'(1) << scan) : '0;
   assign dm_bus.we      = f_ov & f_ordy; // [RULE18]
   assign dm_bus.waddr   = f_od[FIFO_W-1:DM_DW];
   assign dm_bus.wdata   = f_od[DM_DW-1:0];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scan <= '0;
      end else begin
         scan <= (scan == 4'(NSTR-1)) ? 4'd0 : scan + 4'd1;
      end
   end

   tsw_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .pclk      (pclk),
      .presetn   (presetn),
      .in_valid  (f_iv),
      .in_ready  (f_irdy),
      .in_data   ({in_bank[scan], in_ca[9:0], in_byte[scan]}),
      .out_valid (f_ov),
      .out_ready (f_ordy),
      .out_data  (f_od)
   );

   tsw_mem #(.AW(CM_AW), .DW(CM_DW)) u_cm (.pclk(pclk), .m(cm_bus));
   tsw_mem #(.AW(DM_AW), .DW(DM_DW)) u_dm (.pclk(pclk), .m(dm_bus));

   // Prefetch of the next channel for every output stream
   wire [10:0]     pf_ca   = tsw_chan_addr(pf_s, nc, rate);
   wire [15:0]     cm_word = cm_bus.ra_data;
   wire tsw_mode_t s1_mode = tsw_mode_t'(cm_word[CM_MODE +: 2]);
   wire            s1_new  = ((cm_word[7:0] & ch_mask) < nc);
   wire            rd_bank = (cm_word[CM_CONST] | !s1_new) ? !fpar : fpar; // [RULE10]

   assign cm_bus.ra_addr = pf_ca[9:0];
   assign dm_bus.ra_addr = {rd_bank, cm_word[9:0]}; // [RULE2] [RULE5]

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pf_run  <= 1'b0;
         pf_s    <= '0;
         nc      <= '0;
         s1_v    <= 1'b0;
         s1_s    <= '0;
         s1_over <= 1'b0;
         s2_v    <= 1'b0;
         s2_s    <= '0;
         s2_mode <= TSW_MODE_HIZ;
         s2_msg  <= '0;
         s2_hiz  <= 1'b1;
      end else begin
         if (chan_tick) begin
            pf_run <= 1'b1;
            pf_s   <= '0;
            nc     <= (next_gbit[10:3] + 8'd1) & ch_mask;
         end else if (pf_run) begin
            pf_s   <= pf_s + 4'd1;
            pf_run <= (pf_s != 4'(NSTR-1));
         end
         s1_v    <= pf_run;
         s1_s    <= pf_s;
         s1_over <= pf_ca[10];
         s2_v    <= s1_v;
         s2_s    <= s1_s;
         s2_mode <= s1_mode;
         s2_msg  <= cm_word[7:0];
         s2_hiz  <= s1_over | (s1_mode == TSW_MODE_HIZ) | (s1_mode == TSW_MODE_RSVD); // [RULE7]
      end
   end

   // Per stream serial logic and timing registers
   for (genvar s = 0; s < NSTR; s++) begin : g_str
      logic [7:0]  in_sh;
      logic [7:0]  osh;
      logic        ohiz;
      wire         in_bit  = bidir ? serial_out_bidir_stream_i[s] : serial_in_stream[s]; // [RULE4]
      wire [10:0]  in_idx  = (next_gbit - 11'(in_tim[s][2:0])) & fb_mask; // [RULE11]
      wire         sample  = tedge & (next_ep == (in_tim[s][3] ? ep_last : ep_half)); // [RULE11] [RULE16]
      wire         done    = sample & (in_idx[2:0] == 3'd7);
      wire [10:0]  out_pos = (next_gbit + 11'(out_tim[s][1:0]) + 11'(out_tim[s][2])) & fb_mask; // [RULE12]
      wire         launch  = tedge & (next_ep == (out_tim[s][2] ? ep_half : 5'd0)); // [RULE12] [RULE16]
      wire         load    = launch & (out_pos[2:0] == 3'd0);
      wire         tim_sel = (paddr[5:2] == 4'(s));

      assign ovr_set[s] = done & in_pend[s] & !pend_clr[s];
      assign serial_out_bidir_stream_o[s]  = osh[7];
      assign serial_out_bidir_stream_oe[s] = !ohiz; // [RULE7]

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            in_tim[s]  <= '0;
            out_tim[s] <= '0;
            in_sh      <= '0;
            in_byte[s] <= '0;
            in_ch[s]   <= '0;
            in_bank[s] <= 1'b0;
            in_pend[s] <= 1'b0;
         end else begin
            if (wr & hit_in & tim_sel) begin
               in_tim[s] <= pwdata[3:0];
            end
            if (wr & hit_out & tim_sel) begin
               out_tim[s] <= pwdata[2:0];
            end
            if (sample) begin
               in_sh <= {in_sh[6:0], in_bit};
            end
            if (done) begin
               in_byte[s] <= {in_sh[6:0], in_bit}; // [RULE18]
               in_ch[s]   <= in_idx[10:3];
               in_bank[s] <= next_fpar ^ (in_idx > next_gbit);
            end
            in_pend[s] <= done | (in_pend[s] & !pend_clr[s]);
         end
      end

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            nb[s]   <= '0;
            nhiz[s] <= 1'b1;
            osh     <= '0;
            ohiz    <= 1'b1;
         end else begin
            if (s2_v && s2_s == 4'(s)) begin
               nb[s]   <= (s2_mode == TSW_MODE_MSG) ? s2_msg : dm_bus.ra_data; // [RULE5] [RULE6]
               nhiz[s] <= s2_hiz;
            end
            if (load) begin
               osh  <= nb[s];
               ohiz <= nhiz[s]; // [RULE7]
            end else if (launch) begin
               osh <= {osh[6:0], 1'b0};
            end
         end
      end

      chk_bidir_input: assert property (@(posedge pclk) disable iff (!presetn) // [RULE4]
         (sample && bidir) |=> in_sh[0] == $past(serial_out_bidir_stream_i[s]))
         else $error("bidir input not taken from output pin");
      chk_hiz_channel: assert property (@(posedge pclk) disable iff (!presetn) // [RULE7]
         load |=> (serial_out_bidir_stream_oe[s] == !$past(nhiz[s])))
         else $error("output enable does not follow channel mode");
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_frame_wrap: assert property (tedge && frame_start |=> gbit == 11'd0 && ep == 5'd0) // [RULE17]
      else $error("frame pulse did not restart counters");
   chk_bit_range: assert property (gbit <= fb_mask) // [RULE3]
      else $error("bit counter beyond frame length");
   chk_msg_byte: assert property ((s2_v && s2_mode == TSW_MODE_MSG) |=> nb[$past(s2_s)] == $past(s2_msg)) // [RULE6]
      else $error("message byte not loaded");
   chk_conn_byte: assert property ((s2_v && s2_mode == TSW_MODE_CONN) |=> nb[$past(s2_s)] == $past(dm_bus.ra_data)) // [RULE5]
      else $error("switched byte not loaded");
   chk_dm_readonly: assert property ((fire && pwrite && hit_dm) |-> pslverr) // [RULE8]
      else $error("data memory write not refused");
   chk_const_bank: assert property ((s1_v && cm_word[CM_CONST]) |-> dm_bus.ra_addr[10] == !fpar) // [RULE10]
      else $error("constant delay read wrong bank");
   chk_blk_fill: assert property ((blk_st == BLK_IDLE && blk_go) |=> busy [*8] ##0 cm_bus.we && cm_bus.wdata == blk_val) // [RULE15]
      else $error("block programming not writing");
   chk_freeze_stall: assert property (freeze |-> !dm_bus.we) // [RULE18]
      else $error("data memory written while frozen");
   chk_wait_style: assert property ((acc && bus_style_sel && !ack) |-> !pready ##1 pready) // [RULE9]
      else $error("wait state style not honoured");

   cov_block_done: cover property (busy ##1 !busy);
   cov_msg_load: cover property (s2_v && s2_mode == TSW_MODE_MSG);
   cov_fifo_full: cover property (!f_irdy);
   cov_overrun: cover property ($rose(overrun));
endmodule : tsw_core

// [testbench/tsw_tdm_model.sv]
// TDM timing source, serial stream driver and output sampler
module tsw_tdm_model
   import tsw_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [15:0] out_o,
   input  wire logic [15:0] out_oe,
   output logic             tdm_input_clock,
   output logic             frame_pulse_input,
   output logic [15:0]      serial_in_stream,
   output logic [15:0]      bidir_i
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] div;
   logic [9:0] edge_n;
   logic [7:0] bitn;
   int         frames;
   logic [7:0] seen    [16][32];
   logic       seen_oe [16][32];
   function automatic logic [7:0] pat(input int s, input int c);
      return 8'(s * 17 + c * 5 + 3);
   endfunction : pat
   assign bitn = edge_n[9:2];
   // Clock about 4 MHz, 1024 edges a frame
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div <= 3'h0;
         tdm_input_clock <= 1'b0;
         edge_n <= 10'h3ff;
         frames <= 0;
      end else if (div == 3'h4) begin
         div <= 3'h0;
         tdm_input_clock <= ~tdm_input_clock;
         edge_n <= edge_n + 10'h1;
         if (edge_n == 10'h3ff) frames <= frames + 1;
      end else begin
         div <= div + 3'h1;
      end
   end
   // Active low pulse of one clock period around edge 0
   assign frame_pulse_input = !((edge_n == 10'h3ff && div > 3'h1) || edge_n == 10'h0 ||
                                (edge_n == 10'h1 && div < 3'h2));
   // Released bidir pins carry the inverted pattern
   always_comb begin
      logic [7:0] p;
      p = 8'h00;
      for (int s = 0; s < 16; s++) begin
         p = pat(s, int'(bitn[7:3]));
         serial_in_stream[s] = p[~bitn[2:0]];
         bidir_i[s] = out_oe[s] ? out_o[s] : ~p[~bitn[2:0]];
      end
   end
   always_ff @(posedge pclk) begin
      if (div == 3'h2 && edge_n[1:0] == 2'h2) begin
         for (int s = 0; s < 16; s++) begin
            seen[s][bitn[7:3]][~bitn[2:0]] <= out_o[s];
            seen_oe[s][bitn[7:3]] <= out_oe[s];
         end
      end
   end
endmodule : tsw_tdm_model

// [testbench/test_tsw_core.sv]
// Self-checking bench of the timeslot switch core
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin failures++; $display("FAIL %s exp %h got %h", nm, e, g); end end
module test_tsw_core
   import tsw_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, style, tclk, fp, err;
   logic [15:0] paddr, si, bi, so, soe;
   logic [31:0] pwdata, prdata, q;
   int          failures, compares, n;
   tsw_core tsw_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_style_sel(style),
      .tdm_input_clock(tclk), .frame_pulse_input(fp), .serial_in_stream(si), .serial_out_bidir_stream_i(bi),
      .serial_out_bidir_stream_o(so), .serial_out_bidir_stream_oe(soe));
   tsw_tdm_model tsw_tdm_model_inst (.pclk(pclk), .presetn(presetn), .out_o(so), .out_oe(soe),
      .tdm_input_clock(tclk), .frame_pulse_input(fp), .serial_in_stream(si), .bidir_i(bi));
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   task automatic summarize();
      if (failures == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : summarize
   // One APB transfer, held until pready
   task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 20) begin
         failures++;
         summarize();
      end
   endtask : apb
   task automatic rd(input logic [15:0] a);
      apb(1'b0, a, 32'h0);
   endtask : rd
   task automatic frames_wait(input int m);
      int t;
      int k;
      t = tsw_tdm_model_inst.frames + m;
      for (k = 0; k < 6000 * m && tsw_tdm_model_inst.frames < t; k++) @(posedge pclk);
      if (k >= 6000 * m) begin
         failures++;
         summarize();
      end
   endtask : frames_wait
   initial begin
      failures = 0;
      compares = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 16'h0;
      pwdata = 32'h0;
      style = 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd(ADDR_CTRL);
      `CHK("ctrl reset", 32'h0, q)
      rd(ADDR_BLKVAL);
      `CHK("blkval reset", 32'h800, q)
      apb(1'b1, ADDR_CTRL, 32'h80);
      rd(ADDR_STATUS);
      `CHK("busy", 32'h1, q & 32'h1)
      apb(1'b1, 16'h1000, 32'h1);
      `CHK("cm write busy", 1'b1, err)
      n = 0;
      do begin
         rd(ADDR_STATUS);
         n++;
      end while (q[0] !== 1'b0 && n < 600);
      `CHK("block done", 1'b0, q[0])
      rd(16'h1ffc);
      `CHK("cm last", 32'h800, q)
      rd(16'h1000);
      `CHK("cm first", 32'h800, q)
      apb(1'b1, 16'h2000, 32'h1);
      `CHK("dm write", 1'b1, err)
      rd(16'h0010);
      `CHK("unmapped", 1'b1, err)
      style <= 1'b1;
      apb(1'b1, 16'h108c, 32'h04a5);
      apb(1'b1, 16'h1110, 32'h00a7);
      apb(1'b1, 16'h11a4, 32'h10a7);
      rd(16'h108c);
      `CHK("cm readback", 32'h04a5, q)
      frames_wait(3);
      `CHK("message", 8'ha5, tsw_tdm_model_inst.seen[1][3])
      `CHK("oe on", 1'b1, tsw_tdm_model_inst.seen_oe[1][3])
      `CHK("oe before", 1'b0, tsw_tdm_model_inst.seen_oe[1][2])
      `CHK("oe after", 1'b0, tsw_tdm_model_inst.seen_oe[1][4])
      `CHK("connect", 8'h7b, tsw_tdm_model_inst.seen[2][4])
      `CHK("constant", 8'h7b, tsw_tdm_model_inst.seen[3][9])
      rd(16'h229c);
      `CHK("dm bank0", 32'h7b, q)
      rd(16'h329c);
      `CHK("dm bank1", 32'h7b, q)
      apb(1'b1, ADDR_CTRL, 32'h10);
      frames_wait(3);
      rd(16'h229c);
      `CHK("bidir dm", 32'h84, q)
      `CHK("bidir out", 8'h84, tsw_tdm_model_inst.seen[2][4])
      apb(1'b1, ADDR_CTRL, 32'h40);
      frames_wait(1);
      rd(ADDR_STATUS);
      `CHK("overrun frozen", 1'b1, q[1])
      apb(1'b1, ADDR_CTRL, 32'h0);
      frames_wait(1);
      apb(1'b1, ADDR_STATUS, 32'h2);
      rd(ADDR_STATUS);
      `CHK("overrun clear", 1'b0, q[1])
      summarize();
   end
endmodule : test_tsw_core
